// File: rtl/ookm_defs.svh
`ifndef OOKM_DEFS_SVH
`define OOKM_DEFS_SVH

// clocking
`define OOKM_ACLK_NS 20
`define OOKM_REF_KHZ 8704
`define OOKM_CARRIER_DIV 4

// direction hold per rate, in microseconds, and in reference ticks
`define OOKM_DIR_US_SLOW 1667
`define OOKM_DIR_US_MID 417
`define OOKM_DIR_US_FAST 137
`define OOKM_DIR_TICKS(us) (((us) * `OOKM_REF_KHZ) / 1000)

// receiver noise filter, in nanoseconds, and in aclk cycles (rounded up)
`define OOKM_NF_NS_SLOW 4000
`define OOKM_NF_NS_FAST 2000
`define OOKM_NF_CYC(ns) (((ns) + `OOKM_ACLK_NS - 1) / `OOKM_ACLK_NS)

// register bus
`define OOKM_AXI_AW 12
`define OOKM_CTRL_OFS 12'h000
`define OOKM_STATUS_OFS 12'h004
`define OOKM_CTRL_RESET 4'h0
`define OOKM_CTRL_STBY_BIT 0
`define OOKM_CTRL_RATE_EN_BIT 1
`define OOKM_CTRL_RATE_LSB 2
`define OOKM_STAT_MODE_LSB 0
`define OOKM_STAT_DIR_BIT 2
`define OOKM_STAT_RX_BIT 3
`define OOKM_STAT_TX_BIT 4
`define OOKM_STAT_RATE_LSB 5
`define OOKM_STAT_TMO_BIT 7
`define OOKM_RESP_OKAY 2'h0
`define OOKM_RESP_SLVERR 2'h2

`endif

// File: rtl/ookm_pkg.sv
`include "ookm_defs.svh"
`default_nettype none
package ookm_pkg;

  typedef enum logic [1:0] {
    OOKM_IDLE = 2'h0,
    OOKM_RECEIVE = 2'h1,
    OOKM_TRANSMIT = 2'h2,
    OOKM_STANDBY = 2'h3
  } ookm_mode_type;

  // coded as {rate_select_hi, rate_select_lo}
  typedef enum logic [1:0] {
    OOKM_RATE_SLOW = 2'h0,
    OOKM_RATE_MID = 2'h1,
    OOKM_RATE_FAST = 2'h2,
    OOKM_RATE_STBY = 2'h3
  } ookm_rate_type;

  typedef struct packed {
    logic [`OOKM_AXI_AW-1:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [`OOKM_AXI_AW-1:0] araddr;
    logic arvalid;
    logic rready;
  } ookm_axi_req_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ookm_axi_rsp_type;

endpackage
`default_nettype wire

// File: rtl/ookm_sync.sv
`default_nettype none
module ookm_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } ookm_sync_state_type;

  ookm_sync_state_type q;
  ookm_sync_state_type d;

  // meta is read only by stable
  always_comb begin
    d.meta = async_in;
    d.stable = q.meta;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q.meta <= RESET_VAL;
      q.stable <= RESET_VAL;
    end else begin
      q <= d;
    end
  end

  assign sync_out = q.stable;
endmodule
`default_nettype wire

// File: rtl/ookm_carrier.sv
`include "ookm_defs.svh"
`default_nettype none
module ookm_carrier
  import ookm_pkg::*;
#(
  parameter int DIV = `OOKM_CARRIER_DIV
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ref_tick,
  output logic carrier_out
);
  localparam int PW = $clog2(DIV);
  localparam logic [PW-1:0] HALF_LAST = PW'(DIV / 2 - 1);

  typedef struct packed {
    logic [PW-1:0] phase;
    logic carrier;
  } ookm_car_state_type;

  ookm_car_state_type q;
  ookm_car_state_type d;

  // half period of DIV/2 reference ticks
  always_comb begin
    d = q;
    if (ref_tick) begin
      if (q.phase == HALF_LAST) begin
        d.phase = '0;
        d.carrier = ~q.carrier; // [RULE18]
      end else begin
        d.phase = q.phase + 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign carrier_out = q.carrier;

  a_carrier_on_tick: assert property (@(posedge aclk) disable iff (!aresetn)
    $changed(q.carrier) |-> $past(ref_tick) && $past(q.phase) == HALF_LAST)
    else $error("carrier toggled off a half-period boundary"); // [RULE18]
endmodule
`default_nettype wire

// File: rtl/ookm_top.sv
// Behaviour
// RULE1: both rate-select inputs high puts the block into standby.
// RULE2: in standby the receive path keeps detecting carrier for receive out.
// RULE3: in standby the coax output stays quiet whatever the transmit input.
// RULE4: out of standby it starts idle: receive out high, coax quiet.
// RULE5: idle goes receive on valid carrier, transmit on transmit input low.
// RULE6: receive only if not transmitting, transmit only if not receiving.
// RULE7: receive or transmit holds until direction time-out after activity.
// RULE8: in receive, receive out follows every valid carrier, own echo too.
// RULE9: in receive or transmit, coax keyed while transmit input low.
// RULE10: the host keeps transmit input high while the block is receiving.
// RULE11: receive ends sixteen bit times after the last carrier-ending edge.
// RULE12: in transmit, receive out stays high whatever the coax input.
// RULE13: transmit ends sixteen bit times after transmit input returns high.
// RULE14: idle with no carrier: direction low, receive out high.
// RULE15: receive, carrier past noise filter: receive out low, direction high.
// RULE16: receive carrier gaps: receive out high, direction high to time-out.
// RULE17: in transmit, direction low and receive out high until time-out.
// RULE18: the carrier is the reference clock divided by four.
// RULE19: direction follows coax activity, hold time picked by rate select.
// RULE20: unconnected rate-select inputs give the longest hold time.
// RULE21: direction rises on the first valid carrier to claim the local bus.
// RULE22: the integrator sets rate select to match the real data rate.
// RULE23: rate select {hi, lo}: 00 slow, 01 middle, 10 fast, 11 standby.
// RULE24: hold is 1667, 417 or 137 microseconds for slow, middle, fast.
// RULE25: noise filter rejects bursts under 4 us slow, 2 us faster.
// RULE26: time-out counts reference ticks, reloads on activity, limit by rate.
`include "ookm_defs.svh"
`default_nettype none
module ookm_top
  import ookm_pkg::*;
#(
  parameter int DIR_TICKS_SLOW = `OOKM_DIR_TICKS(`OOKM_DIR_US_SLOW),
  parameter int DIR_TICKS_MID = `OOKM_DIR_TICKS(`OOKM_DIR_US_MID),
  parameter int DIR_TICKS_FAST = `OOKM_DIR_TICKS(`OOKM_DIR_US_FAST),
  parameter int NF_CYC_SLOW = `OOKM_NF_CYC(`OOKM_NF_NS_SLOW),
  parameter int NF_CYC_FAST = `OOKM_NF_CYC(`OOKM_NF_NS_FAST)
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire ookm_axi_req_type axi_req,
  output ookm_axi_rsp_type axi_rsp,
  input wire logic rate_select_lo,
  input wire logic rate_select_hi,
  input wire logic coax_receive_in,
  input wire logic baseband_transmit_in,
  input wire logic reference_clock_in_a,
  input wire logic reference_clock_in_b,
  output logic baseband_receive_out,
  output logic bus_direction_out,
  output logic coax_transmit_out
);
  localparam logic [15:0] TMO_SLOW = 16'(DIR_TICKS_SLOW);
  localparam logic [15:0] TMO_MID = 16'(DIR_TICKS_MID);
  localparam logic [15:0] TMO_FAST = 16'(DIR_TICKS_FAST);
  localparam logic [7:0] NF_SLOW = 8'(NF_CYC_SLOW);
  localparam logic [7:0] NF_FAST = 8'(NF_CYC_FAST);
  // idle transmit pin is high; resetting its synchroniser low would fake a send
  localparam logic [5:0] SYNC_RESET = 6'h08;

  typedef struct packed {
    ookm_mode_type mode;
    ookm_rate_type rate;
    logic [15:0] tmo;
    logic [7:0] nf_cnt;
    logic carrier_valid;
    logic ref_prev;
    logic rx_out;
    logic dir;
    logic tx_out;
    logic [3:0] ctrl;
    logic [`OOKM_AXI_AW-1:0] awaddr;
    logic aw_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic w_have;
    ookm_axi_rsp_type rsp;
  } ookm_state_type;

  ookm_state_type q;
  ookm_state_type d;

  logic [5:0] pins_s;
  logic rate_lo_s;
  logic rate_hi_s;
  logic rx_s;
  logic tx_s;
  logic ref_s;
  logic ref_tick;
  logic carrier;

  ookm_sync #(
    .WIDTH(6),
    .RESET_VAL(SYNC_RESET)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({reference_clock_in_b, reference_clock_in_a,
               baseband_transmit_in, coax_receive_in,
               rate_select_hi, rate_select_lo}),
    .sync_out(pins_s)
  );

  assign rate_lo_s = pins_s[0];
  assign rate_hi_s = pins_s[1];
  assign rx_s = pins_s[2];
  assign tx_s = pins_s[3];
  // crystal across both pins or a clock on one with the other grounded
  assign ref_s = pins_s[4] ^ pins_s[5];
  assign ref_tick = ref_s & ~q.ref_prev;

  ookm_carrier #(
    .DIV(`OOKM_CARRIER_DIV)
  ) u_carrier (
    .aclk(aclk),
    .aresetn(aresetn),
    .ref_tick(ref_tick),
    .carrier_out(carrier)
  );

  function automatic logic [15:0] tmo_limit(input ookm_rate_type r);
    logic [15:0] v;
    v = TMO_SLOW;
    if (r == OOKM_RATE_MID) begin
      v = TMO_MID;
    end else if (r == OOKM_RATE_FAST) begin
      v = TMO_FAST;
    end
    return v; // [RULE24]
  endfunction

  function automatic logic [7:0] nf_limit(input ookm_rate_type r);
    return (r == OOKM_RATE_SLOW) ? NF_SLOW : NF_FAST; // [RULE25]
  endfunction

  logic standby;
  logic [31:0] status_word;

  always_comb begin
    d = q;
    standby = 1'b0;
    status_word = '0;
    d.ref_prev = ref_s;

    // rate: pins unless software overrides; open pins read low = slowest
    if (q.ctrl[`OOKM_CTRL_STBY_BIT]) begin
      d.rate = OOKM_RATE_STBY;
    end else if (q.ctrl[`OOKM_CTRL_RATE_EN_BIT]) begin
      d.rate = ookm_rate_type'(q.ctrl[`OOKM_CTRL_RATE_LSB +: 2]);
    end else begin
      d.rate = ookm_rate_type'({rate_hi_s, rate_lo_s}); // [RULE23] [RULE20]
    end
    standby = (q.rate == OOKM_RATE_STBY);

    // noise filter: a carrier burst must last nf_limit cycles to count
    if (!rx_s) begin
      d.nf_cnt = '0;
      d.carrier_valid = 1'b0;
    end else if (!q.carrier_valid) begin
      if (q.nf_cnt >= nf_limit(q.rate) - 8'h01) begin
        d.carrier_valid = 1'b1; // [RULE25]
      end else begin
        d.nf_cnt = q.nf_cnt + 8'h01;
      end
    end

    case (q.mode)
      OOKM_IDLE: begin
        if (standby) begin
          d.mode = OOKM_STANDBY; // [RULE1]
        end else if (q.carrier_valid) begin
          d.mode = OOKM_RECEIVE; // [RULE5] [RULE21]
          d.tmo = tmo_limit(q.rate);
        end else if (!tx_s) begin
          d.mode = OOKM_TRANSMIT; // [RULE5]
          d.tmo = tmo_limit(q.rate);
        end
      end
      OOKM_RECEIVE: begin
        // transmit is never entered from here [RULE6]
        if (standby) begin
          d.mode = OOKM_STANDBY; // [RULE1]
        end else if (q.carrier_valid) begin
          d.tmo = tmo_limit(q.rate); // [RULE26] [RULE11]
        end else if (q.tmo == 16'h0000) begin
          d.mode = OOKM_IDLE; // [RULE7]
        end else if (ref_tick) begin
          d.tmo = q.tmo - 16'h0001; // [RULE26]
        end
      end
      OOKM_TRANSMIT: begin
        // receive is never entered from here [RULE6]
        if (standby) begin
          d.mode = OOKM_STANDBY; // [RULE1]
        end else if (!tx_s) begin
          d.tmo = tmo_limit(q.rate); // [RULE26] [RULE13]
        end else if (q.tmo == 16'h0000) begin
          d.mode = OOKM_IDLE; // [RULE7]
        end else if (ref_tick) begin
          d.tmo = q.tmo - 16'h0001; // [RULE26]
        end
      end
      default: begin
        if (!standby) begin
          d.mode = OOKM_IDLE; // [RULE4]
        end
      end
    endcase

    // pin outputs follow the next mode so they switch with it
    d.rx_out = 1'b1; // [RULE4] [RULE12] [RULE14] [RULE17]
    if (d.mode == OOKM_RECEIVE || d.mode == OOKM_STANDBY) begin
      d.rx_out = ~q.carrier_valid; // [RULE2] [RULE8] [RULE15] [RULE16]
    end
    d.dir = (d.mode == OOKM_RECEIVE); // [RULE15] [RULE16] [RULE19]
    d.tx_out = 1'b0; // [RULE3]
    if (d.mode == OOKM_RECEIVE || d.mode == OOKM_TRANSMIT) begin
      d.tx_out = ~tx_s & carrier; // [RULE9]
    end

    // register bus: address and data taken in either order
    status_word[`OOKM_STAT_MODE_LSB +: 2] = q.mode;
    status_word[`OOKM_STAT_DIR_BIT] = q.dir;
    status_word[`OOKM_STAT_RX_BIT] = q.rx_out;
    status_word[`OOKM_STAT_TX_BIT] = q.tx_out;
    status_word[`OOKM_STAT_RATE_LSB +: 2] = q.rate;
    status_word[`OOKM_STAT_TMO_BIT] = (q.tmo != 16'h0000);

    if (axi_req.awvalid && q.rsp.awready) begin
      d.awaddr = axi_req.awaddr;
      d.aw_have = 1'b1;
    end
    if (axi_req.wvalid && q.rsp.wready) begin
      d.wdata = axi_req.wdata;
      d.wstrb = axi_req.wstrb;
      d.w_have = 1'b1;
    end
    if (q.rsp.bvalid && axi_req.bready) begin
      d.rsp.bvalid = 1'b0;
    end
    if (q.aw_have && q.w_have && !q.rsp.bvalid) begin
      d.aw_have = 1'b0;
      d.w_have = 1'b0;
      d.rsp.bvalid = 1'b1;
      d.rsp.bresp = `OOKM_RESP_OKAY;
      if (q.awaddr == `OOKM_CTRL_OFS) begin
        if (q.wstrb[0]) begin
          d.ctrl = q.wdata[3:0];
        end
      end else if (q.awaddr == `OOKM_STATUS_OFS) begin
        d.rsp.bresp = `OOKM_RESP_OKAY;
      end else begin
        d.rsp.bresp = `OOKM_RESP_SLVERR;
      end
    end
    d.rsp.awready = ~d.aw_have;
    d.rsp.wready = ~d.w_have;

    if (q.rsp.rvalid && axi_req.rready) begin
      d.rsp.rvalid = 1'b0;
    end
    if (axi_req.arvalid && q.rsp.arready) begin
      d.rsp.rvalid = 1'b1;
      d.rsp.rresp = `OOKM_RESP_OKAY;
      if (axi_req.araddr == `OOKM_CTRL_OFS) begin
        d.rsp.rdata = {28'h0000000, q.ctrl};
      end else if (axi_req.araddr == `OOKM_STATUS_OFS) begin
        d.rsp.rdata = status_word;
      end else begin
        d.rsp.rdata = 32'h00000000;
        d.rsp.rresp = `OOKM_RESP_SLVERR;
      end
    end
    d.rsp.arready = ~d.rsp.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.mode <= OOKM_IDLE;
      q.rate <= OOKM_RATE_SLOW;
      q.ctrl <= `OOKM_CTRL_RESET;
      q.rx_out <= 1'b1;
      q.rsp.awready <= 1'b1;
      q.rsp.wready <= 1'b1;
      q.rsp.arready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign axi_rsp = q.rsp;
  assign baseband_receive_out = q.rx_out;
  assign bus_direction_out = q.dir;
  assign coax_transmit_out = q.tx_out;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_standby_entry: assert property ( // [RULE1]
    q.rate == OOKM_RATE_STBY && q.mode != OOKM_STANDBY
      |=> q.mode == OOKM_STANDBY)
    else $error("standby select did not enter standby");

  a_standby_quiet: assert property ( // [RULE3]
    q.mode == OOKM_STANDBY |-> !coax_transmit_out)
    else $error("coax output active in standby");

  a_standby_rx_path: assert property ( // [RULE2]
    q.mode == OOKM_STANDBY && $past(q.mode) == OOKM_STANDBY
      |-> baseband_receive_out == !$past(q.carrier_valid))
    else $error("receive path not working in standby");

  a_idle_outputs: assert property ( // [RULE14]
    q.mode == OOKM_IDLE
      |-> baseband_receive_out && !bus_direction_out && !coax_transmit_out)
    else $error("idle outputs wrong");

  a_rx_entry: assert property ( // [RULE5]
    q.mode == OOKM_IDLE && q.carrier_valid && q.rate != OOKM_RATE_STBY
      |=> q.mode == OOKM_RECEIVE && bus_direction_out)
    else $error("valid carrier in idle did not start receive");

  a_tx_no_rx: assert property ( // [RULE12]
    q.mode == OOKM_TRANSMIT |-> baseband_receive_out && !bus_direction_out)
    else $error("transmit mode shows receive activity");

  a_rx_follow: assert property ( // [RULE8]
    q.mode == OOKM_RECEIVE && $past(q.mode) == OOKM_RECEIVE
      |-> baseband_receive_out == !$past(q.carrier_valid) && bus_direction_out)
    else $error("receive out does not follow carrier");

  a_tx_carrier: assert property ( // [RULE9]
    coax_transmit_out |-> $past(!tx_s) && $past(carrier))
    else $error("coax output keyed without transmit request");

  a_rx_hold: assert property ( // [RULE7]
    q.mode == OOKM_RECEIVE && !q.carrier_valid && q.tmo != 16'h0000
      && q.rate != OOKM_RATE_STBY |=> q.mode == OOKM_RECEIVE)
    else $error("receive mode left before time-out");

  a_tmo_end: assert property ( // [RULE13]
    q.mode == OOKM_TRANSMIT && tx_s && q.tmo == 16'h0000
      && q.rate != OOKM_RATE_STBY |=> q.mode == OOKM_IDLE)
    else $error("transmit mode not left at time-out");

  a_noise_reject: assert property ( // [RULE25]
    $rose(q.carrier_valid) |-> $past(rx_s, 1) && $past(rx_s, 2)
      && $past(q.nf_cnt) == nf_limit($past(q.rate)) - 8'h01)
    else $error("carrier accepted before noise filter time");

  c_receive: cover property (q.mode == OOKM_IDLE ##1 q.mode == OOKM_RECEIVE);
  c_transmit: cover property (q.mode == OOKM_IDLE ##1 q.mode == OOKM_TRANSMIT);
  c_standby: cover property (q.mode == OOKM_STANDBY ##1 q.mode == OOKM_IDLE);
  c_timeout: cover property (q.mode == OOKM_RECEIVE ##1 q.mode == OOKM_IDLE);
endmodule
`default_nettype wire

// File: tb/ookm_far_end.sv
`default_nettype none
module ookm_far_end
  import ookm_pkg::*;
#(
  parameter real REF_HALF_NS = 57.445
) (
  input wire logic carrier_on,
  input wire logic bus_direction_out,
  output logic coax_receive_in,
  output logic reference_clock_in_a,
  output logic reference_clock_in_b,
  output logic bus_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_q = 1'b0;
  // free-running oscillator, unrelated in phase to aclk
  always #(REF_HALF_NS) ref_q = ~ref_q;
  assign reference_clock_in_a = ref_q;
  // second crystal pin grounded when a clock source drives the first
  assign reference_clock_in_b = 1'b0;
  // remote modem: detector output high while its carrier is on the cable
  assign coax_receive_in = carrier_on;
  // local rs-485 transceiver enable simply follows the direction output
  assign bus_enable = bus_direction_out;
endmodule
`default_nettype wire

// File: tb/tb.sv
`include "ookm_defs.svh"
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module tb
  import ookm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam real REF_NS = 114.89;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  ookm_axi_req_type req = '0;
  ookm_axi_rsp_type rsp;
  logic rs_lo = 1'b0;
  logic rs_hi = 1'b0;
  logic tx_in = 1'b1;
  logic carrier_on = 1'b0;
  logic ref_a, ref_b, coax_in, rx_out, dir_out, coax_out, bus_en;
  int err_total = 0;
  int checks = 0;
  int seed = 32'h6fa9cfdf;
  int cyc = 0;
  // small counts keep the run short; expectations scale from these
  int hold_ticks[3] = '{20, 10, 5};
  int nf_cyc[3] = '{8, 4, 4};

  always #10 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;

  ookm_top #(.DIR_TICKS_SLOW(20), .DIR_TICKS_MID(10), .DIR_TICKS_FAST(5),
    .NF_CYC_SLOW(8), .NF_CYC_FAST(4)) i_ookm_top (
    .aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
    .rate_select_lo(rs_lo), .rate_select_hi(rs_hi),
    .coax_receive_in(coax_in), .baseband_transmit_in(tx_in),
    .reference_clock_in_a(ref_a), .reference_clock_in_b(ref_b),
    .baseband_receive_out(rx_out), .bus_direction_out(dir_out),
    .coax_transmit_out(coax_out));

  ookm_far_end i_ookm_far_end (
    .carrier_on(carrier_on), .bus_direction_out(dir_out),
    .coax_receive_in(coax_in), .reference_clock_in_a(ref_a),
    .reference_clock_in_b(ref_b), .bus_enable(bus_en));

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    int n;
    n = 0;
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    forever begin
      @(posedge aclk);
      n++;
      if (req.awvalid && rsp.awready === 1'b1) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready === 1'b1) req.wvalid <= 1'b0;
      if (rsp.bvalid === 1'b1 || n > 200) break;
    end
    // bready and rready stay high so back-to-back calls never clash
    r = rsp.bresp;
    if (n > 200) err_total++;
  endtask

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    int n;
    n = 0;
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    forever begin
      @(posedge aclk);
      n++;
      if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
      if (rsp.rvalid === 1'b1 || n > 200) break;
    end
    d = rsp.rdata;
    r = rsp.rresp;
    if (n > 200) err_total++;
  endtask

  // model: {receive out, direction} from mode and carrier on the cable
  function automatic logic [1:0] exp_pins(input logic [1:0] m,
                                          input logic car);
    case (m)
      2'h1: return {~car, 1'b1};
      2'h3: return {~car, 1'b0};
      default: return 2'b10;
    endcase
  endfunction

  task automatic observe(input logic [1:0] m, input logic car);
    logic [31:0] d;
    logic [1:0] r;
    logic [1:0] e;
    e = exp_pins(m, car);
    `CHK("rx_out", e[1], rx_out)
    `CHK("dir", e[0], dir_out)
    if (m == 2'h0 || m == 2'h3 || tx_in) `CHK("coax_out", 1'b0, coax_out)
    `CHK("bus_en", e[0], bus_en)
    axi_rd(`OOKM_STATUS_OFS, d, r);
    `CHK("mode", m, d[1:0])
    `CHK("st dir", e[0], d[`OOKM_STAT_DIR_BIT])
    `CHK("st rx", e[1], d[`OOKM_STAT_RX_BIT])
  endtask

  task automatic edges(input int n, output int re, output int te);
    logic pr, pt;
    re = 0;
    te = 0;
    pr = ref_a;
    pt = coax_out;
    repeat (n) begin
      @(posedge aclk);
      if (ref_a && !pr) re++;
      if (coax_out && !pt) te++;
      pr = ref_a;
      pt = coax_out;
    end
  endtask

  initial begin
    #400000;
    err_total++;
    test_done();
  end

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int re, te, t0, exp_c, dt;
    tick(4);
    aresetn <= 1'b1;
    tick(6);
    observe(2'h0, 1'b0);
    axi_rd(`OOKM_CTRL_OFS, d, r);
    `CHK("ctrl reset", 32'h0, d)
    axi_rd(12'h010, d, r);
    `CHK("unmapped rresp", `OOKM_RESP_SLVERR, r)
    axi_wr(`OOKM_STATUS_OFS, 32'hFF, r);
    `CHK("status wresp", `OOKM_RESP_OKAY, r)
    axi_wr(12'h010, 32'h1, r);
    `CHK("unmapped wresp", `OOKM_RESP_SLVERR, r)
    axi_rd(`OOKM_CTRL_OFS, d, r);
    `CHK("ctrl unchanged", 32'h0, d)
    // software rate override: fast while the pins still say slow
    axi_wr(`OOKM_CTRL_OFS, 32'h0000000A, r);
    tick(4);
    axi_rd(`OOKM_STATUS_OFS, d, r);
    `CHK("rate override", 2'h2, d[`OOKM_STAT_RATE_LSB +: 2])
    axi_wr(`OOKM_CTRL_OFS, 32'h0, r);
    $display("test reset finished");
    for (int k = 0; k < 3; k++) begin
      rs_hi <= k[1];
      rs_lo <= k[0];
      tick(8);
      axi_rd(`OOKM_STATUS_OFS, d, r);
      `CHK("rate", k[1:0], d[`OOKM_STAT_RATE_LSB +: 2])
      carrier_on <= 1'b1;
      tick(nf_cyc[k] - 3);
      carrier_on <= 1'b0;
      tick(10);
      observe(2'h0, 1'b0);
      carrier_on <= 1'b1;
      tick(nf_cyc[k] + 6 + ($random(seed) & 15));
      observe(2'h1, 1'b1);
      carrier_on <= 1'b0;
      t0 = cyc;
      tick(6);
      observe(2'h1, 1'b0);
      while (dir_out === 1'b1 && cyc - t0 < 1000) tick(1);
      exp_c = int'(hold_ticks[k] * REF_NS / 20.0);
      dt = cyc - t0;
      `CHK("hold", 1'b1, dt > exp_c - 12 && dt < exp_c + 12)
      observe(2'h0, 1'b0);
    end
    $display("test rates finished");
    rs_hi <= 1'b0;
    rs_lo <= 1'b0;
    tick(8);
    tx_in <= 1'b0;
    tick(8);
    observe(2'h2, 1'b0);
    carrier_on <= 1'b1;
    tick(20);
    observe(2'h2, 1'b1);
    carrier_on <= 1'b0;
    edges(460, re, te);
    `CHK("carrier", 1'b1, te * 4 > re - 8 && te * 4 < re + 8)
    tx_in <= 1'b1;
    tick(20);
    edges(50, re, te);
    `CHK("quiet", 0, te)
    observe(2'h2, 1'b0);
    tick(120);
    observe(2'h0, 1'b0);
    $display("test transmit finished");
    carrier_on <= 1'b1;
    tick(20);
    // host drives transmit low while receiving, against the usual practice
    tx_in <= 1'b0;
    edges(60, re, te);
    `CHK("keyed", 1'b1, te > 0)
    observe(2'h1, 1'b1);
    tx_in <= 1'b1;
    carrier_on <= 1'b0;
    tick(300);
    observe(2'h0, 1'b0);
    $display("test overlap finished");
    rs_hi <= 1'b1;
    rs_lo <= 1'b1;
    tick(8);
    observe(2'h3, 1'b0);
    tx_in <= 1'b0;
    edges(60, re, te);
    `CHK("standby tx", 0, te)
    tx_in <= 1'b1;
    carrier_on <= 1'b1;
    tick(20);
    observe(2'h3, 1'b1);
    carrier_on <= 1'b0;
    rs_hi <= 1'b0;
    rs_lo <= 1'b0;
    tick(8);
    observe(2'h0, 1'b0);
    axi_wr(`OOKM_CTRL_OFS, 32'h1, r);
    tick(4);
    observe(2'h3, 1'b0);
    axi_rd(`OOKM_CTRL_OFS, d, r);
    `CHK("ctrl", 32'h1, d)
    axi_wr(`OOKM_CTRL_OFS, 32'h0, r);
    tick(4);
    observe(2'h0, 1'b0);
    $display("test standby finished");
    test_done();
  end
endmodule
`default_nettype wire
